/* hw/ccz_ctl0.v */
/*
 * Control register zero of a CAN controller: frame flag, receiver and
 * synchronization status, stop in wait, time-stamp timer, wake enable,
 * sleep and init requests, reached over an AXI4-Lite slave.
 * Assumes the protocol engine supplies receive events, idle status and
 * its transmit bit, and drains time stamps from the FIFO.
 */
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "ccz_defines.vh"
module ccz_ctl0 #(
  parameter BIT_DIV = `CCZ_BIT_DIV,
  parameter IDX_W   = 4,
  parameter DEPTH   = 32
) (
  input  wire                core_clk,
  input  wire                resetn,
  // axi4-lite slave
  input  wire [3:0]          s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output reg                 s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output reg                 s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [3:0]          s_axi_araddr,
  input  wire                s_axi_arvalid,
  output reg                 s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  // can pins
  input  wire                bus_receive_pin,
  output reg                 bus_transmit_pin,
  // protocol engine side
  input  wire                engine_tx_bit,
  input  wire                engine_frame_ok,
  input  wire                engine_receiving,
  input  wire                engine_synced,
  input  wire                engine_tx_empty,
  input  wire                engine_msg_ack,
  input  wire [IDX_W-1:0]    engine_msg_buf,
  input  wire                cpu_wait_mode,
  output reg                 engine_abort,
  output reg                 init_acknowledge,
  output reg                 sleep_acknowledge,
  output wire                stamp_ready,
  output wire                stamp_valid,
  input  wire                stamp_take,
  output wire [IDX_W+15:0]   stamp_data
);
  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  reg         frame_received_flag;
  reg         receiver_active;
  reg         stop_in_wait;
  reg         bus_synchronized;
  reg         timer_en_q;
  reg         wake_enable;
  reg         sleep_request;
  reg         init_request;
  reg [15:0]  timer_q;
  reg [15:0]  div_q;
  reg         bit_tick_q;
  reg         rx_prev_q;
  wire        init_mode;
  wire        out_of_init;
  wire        gated;

  assign init_mode   = init_request & init_acknowledge;
  assign out_of_init = ~init_request & ~init_acknowledge;
  // bus interface clocks stop in wait mode when enabled
  assign gated       = stop_in_wait & cpu_wait_mode;

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  reg         aw_full_q;
  reg         w_full_q;
  reg [3:0]   aw_addr_q;
  reg [31:0]  w_data_q;
  reg         w_lane0_q;
  reg         aw_full_d;
  reg         w_full_d;
  reg         bvalid_d;
  wire        aw_hs;
  wire        w_hs;
  wire        do_wr;
  wire        ctl_wr;

  assign aw_hs  = s_axi_awvalid & s_axi_awready;
  assign w_hs   = s_axi_wvalid & s_axi_wready;
  assign do_wr  = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign ctl_wr = do_wr & (aw_addr_q == `CCZ_OFF_CTL0) & w_lane0_q;

  always @* begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    bvalid_d  = s_axi_bvalid;
    if (s_axi_bvalid & s_axi_bready)
      bvalid_d = 1'b0;
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
    end
    if (aw_hs)
      aw_full_d = 1'b1;
    if (w_hs)
      w_full_d = 1'b1;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0000_0000;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCZ_RESP_OK;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_awready <= ~gated & ~aw_full_d & ~bvalid_d;
      s_axi_wready  <= ~gated & ~w_full_d & ~bvalid_d;
      if (aw_hs)
        aw_addr_q <= s_axi_awaddr;
      if (w_hs) begin
        w_data_q  <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (do_wr)
        s_axi_bresp <= (aw_addr_q == `CCZ_OFF_CTL0 || aw_addr_q == `CCZ_OFF_STAT ||
                        aw_addr_q == `CCZ_OFF_TIMER) ? `CCZ_RESP_OK : `CCZ_RESP_ERR;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  reg         rvalid_d;
  wire        ar_hs;
  wire [7:0]  ctl0_view;

  assign ar_hs     = s_axi_arvalid & s_axi_arready;
  assign ctl0_view = {frame_received_flag, receiver_active, stop_in_wait,
                      bus_synchronized, timer_en_q, wake_enable, sleep_request,
                      init_request};

  always @* begin
    rvalid_d = s_axi_rvalid;
    if (s_axi_rvalid & s_axi_rready)
      rvalid_d = 1'b0;
    if (ar_hs)
      rvalid_d = 1'b1;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CCZ_RESP_OK;
    end else begin
      s_axi_rvalid  <= rvalid_d;
      s_axi_arready <= ~gated & ~rvalid_d & ~ar_hs;
      // whole word captured in one edge from registered state
      if (ar_hs) begin
        s_axi_rresp <= `CCZ_RESP_OK;
        case (s_axi_araddr)
          `CCZ_OFF_CTL0:  s_axi_rdata <= {24'h00_0000, ctl0_view};
          `CCZ_OFF_STAT:  s_axi_rdata <= {30'h0000_0000, sleep_acknowledge,
                                          init_acknowledge};
          `CCZ_OFF_TIMER: s_axi_rdata <= {16'h0000, timer_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CCZ_RESP_ERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // request bits and handshakes
  // ----------------------------------------------------------------
  wire rx_fall;

  assign rx_fall = rx_prev_q & ~bus_receive_pin;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      init_request      <= `CCZ_INIT_RST;
      init_acknowledge  <= 1'b0;
      sleep_request     <= 1'b0;
      sleep_acknowledge <= 1'b0;
      wake_enable       <= 1'b0;
      engine_abort      <= `CCZ_INIT_RST;
      rx_prev_q         <= `CCZ_RECESSIVE;
    end else begin
      rx_prev_q <= bus_receive_pin;
      // init request writable in any mode; cannot drop before acknowledge
      if (ctl_wr && (w_data_q[`CCZ_B_INIT] || init_acknowledge))
        init_request <= w_data_q[`CCZ_B_INIT];
      // traffic is dropped and acknowledge given on the same edge, one cycle after the request
      engine_abort     <= init_request;
      init_acknowledge <= init_request;
      if (ctl_wr && out_of_init) begin
        wake_enable <= w_data_q[`CCZ_B_WAKE];
        if (w_data_q[`CCZ_B_SLEEP] || sleep_acknowledge)
          sleep_request <= w_data_q[`CCZ_B_SLEEP];
      end else if (sleep_acknowledge && wake_enable && rx_fall) begin
        sleep_request <= 1'b0;
      end
      // sleep only once nothing is received and transmit is empty
      if (!sleep_request)
        sleep_acknowledge <= 1'b0;
      else if (!receiver_active && engine_tx_empty && !init_request)
        sleep_acknowledge <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status and configuration bits held at reset in init mode
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_received_flag <= 1'b0;
      receiver_active     <= 1'b0;
      bus_synchronized    <= 1'b0;
      stop_in_wait        <= 1'b0;
      timer_en_q          <= 1'b0;
    end else if (init_mode) begin
      frame_received_flag <= 1'b0;
      receiver_active     <= 1'b0;
      bus_synchronized    <= 1'b0;
      stop_in_wait        <= 1'b0;
      timer_en_q          <= 1'b0;
    end else begin
      receiver_active  <= engine_receiving & ~init_request;
      bus_synchronized <= engine_synced & ~init_request;
      // a new frame outranks a same-cycle clear
      if (engine_frame_ok)
        frame_received_flag <= 1'b1;
      else if (ctl_wr && out_of_init && w_data_q[`CCZ_B_FRAME])
        frame_received_flag <= 1'b0;
      if (ctl_wr && out_of_init) begin
        stop_in_wait <= w_data_q[`CCZ_B_STOPW];
        timer_en_q   <= w_data_q[`CCZ_B_TIMER];
      end
    end
  end

  // ----------------------------------------------------------------
  // bit-rate divider and time-stamp timer
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_q      <= 16'h0000;
      bit_tick_q <= 1'b0;
      timer_q    <= 16'h0000;
    end else begin
      bit_tick_q <= 1'b0;
      if (!timer_en_q) begin
        div_q   <= 16'h0000;
        timer_q <= 16'h0000;
      end else begin
        if (div_q == BIT_DIV[15:0] - 16'h0001) begin
          div_q      <= 16'h0000;
          bit_tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 16'h0001;
        end
        if (bit_tick_q)
          timer_q <= timer_q + 16'h0001;
      end
    end
  end

  // stamp goes out with its buffer index; the engine writes it to the
  // two top bytes of that buffer. a full FIFO drops ready to the engine.
  ccz_fifo #(
    .WIDTH (IDX_W + 16),
    .DEPTH (DEPTH),
    .AW    (5)
  ) u_stamp_fifo (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .in_valid    (engine_msg_ack & timer_en_q),
    .in_ready_q  (stamp_ready),
    .in_data     ({engine_msg_buf, timer_q}),
    .out_valid_q (stamp_valid),
    .out_ready   (stamp_take),
    .out_data_q  (stamp_data)
  );

  // ----------------------------------------------------------------
  // transmit pin: recessive while init, sleep or stopped in wait
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      bus_transmit_pin <= `CCZ_RECESSIVE;
    else if (init_request || sleep_acknowledge || gated)
      bus_transmit_pin <= `CCZ_RECESSIVE;
    else
      bus_transmit_pin <= engine_tx_bit;
  end
endmodule

/* hw/ccz_defines.vh */
/*
 * Constants for the control-register-zero block: register offsets, bit
 * positions, reset values and timing counts.
 * Assumes it is included by bare name by the design files.
 */
`ifndef CCZ_DEFINES_VH
`define CCZ_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CCZ_OFF_CTL0    4'h0
`define CCZ_OFF_STAT    4'h4
`define CCZ_OFF_TIMER   4'h8

// ----------------------------------------------------------------
// control register zero bit positions
// ----------------------------------------------------------------
`define CCZ_B_FRAME     7
`define CCZ_B_RECEIVER_ACTIVE     6
`define CCZ_B_STOPW     5
`define CCZ_B_SYNC      4
`define CCZ_B_TIMER     3
`define CCZ_B_WAKE      2
`define CCZ_B_SLEEP     1
`define CCZ_B_INIT      0

// ----------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------
`define CCZ_S_INIT_ACKNOWLEDGE    0
`define CCZ_S_SLEEPAK   1

// ----------------------------------------------------------------
// reset values and answers
// ----------------------------------------------------------------
`define CCZ_INIT_RST    1'b1
`define CCZ_RESP_OK     2'b00
`define CCZ_RESP_ERR    2'b10
`define CCZ_RECESSIVE   1'b1

// ----------------------------------------------------------------
// timing: bit period in clock cycles at 50 MHz (core_clk)
// ----------------------------------------------------------------
`define CCZ_CLK_MHZ     50
`define CCZ_BIT_NS      1000
`define CCZ_BIT_DIV     ((`CCZ_BIT_NS * `CCZ_CLK_MHZ) / 1000)

`endif

/* hw/ccz_fifo.v */
/*
 * Time-stamp FIFO with registered read data and registered ready.
 * Assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module ccz_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             core_clk,
  input  wire             resetn,
  input  wire             in_valid,
  output reg              in_ready_q,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid_q,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  reg [AW:0]      count_d;
  wire            push;
  wire            pop;

  assign push = in_valid & in_ready_q;
  // the output register refills whenever memory holds an entry and the register is empty or being taken
  assign pop  = (count_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  always @* begin
    count_d = count_q;
    if (push & ~pop)
      count_d = count_q + 1'b1;
    else if (pop & ~push)
      count_d = count_q - 1'b1;
  end

  always @(posedge core_clk) begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q    <= {AW{1'b0}};
      rd_ptr_q    <= {AW{1'b0}};
      count_q     <= {(AW+1){1'b0}};
      in_ready_q  <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= {WIDTH{1'b0}};
    end else begin
      count_q    <= count_d;
      in_ready_q <= (count_d != DEPTH[AW:0]);
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) begin
        rd_ptr_q    <= rd_ptr_q + 1'b1;
        out_data_q  <= mem[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule

/* test/ccz_ctl0_sva.sv */
/*
 * Port checker for ccz_ctl0: register bus timing, transmit pin, stamps.
 * Assumes one clock domain, resetn active low, bound by port name.
 */
`timescale 1ns/1ps
module ccz_ctl0_sva #(
  parameter IDX_W = 4
) (
  input logic              core_clk,
  input logic              resetn,
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic              s_axi_wvalid,
  input logic              s_axi_wready,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  input logic              bus_transmit_pin,
  input logic              engine_tx_bit,
  input logic              engine_receiving,
  input logic              engine_tx_empty,
  input logic              cpu_wait_mode,
  input logic              engine_abort,
  input logic              init_acknowledge,
  input logic              sleep_acknowledge,
  input logic              stamp_valid,
  input logic              stamp_take,
  input logic [IDX_W+15:0] stamp_data
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // wait mode is excluded wholesale since stop-in-wait is not visible here
  chk_tx_follow: assert property (
    !engine_abort && $past(!sleep_acknowledge && !cpu_wait_mode)
    |-> bus_transmit_pin == $past(engine_tx_bit)) else $error("tx pin off engine bit");
  chk_abort_quiet: assert property (engine_abort |-> bus_transmit_pin)
    else $error("tx pin dominant during abort");
  chk_ack_abort: assert property ($past(resetn) |-> init_acknowledge == engine_abort)
    else $error("init ack and abort differ");
  chk_b_after: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during answer");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_r_after: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_sleep_idle: assert property ($rose(sleep_acknowledge) |->
    $past(engine_tx_empty) && !$past(engine_receiving, 2) && !engine_abort)
    else $error("sleep entered while busy");
  chk_stamp_hold: assert property (
    stamp_valid && !stamp_take |=> stamp_valid && $stable(stamp_data))
    else $error("stamp dropped before take");

  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_sleep: cover property ($rose(sleep_acknowledge));
  cov_stamp: cover property (stamp_valid && stamp_take);
endmodule

bind ccz_ctl0 ccz_ctl0_sva #(.IDX_W(IDX_W)) u_sva (.*);

/* test/ccz_bus_node.sv */
/*
 * Other node on the bus behind a transceiver: wired-and of both drivers.
 * Assumes the bench pulses wake_go for one cycle to send a dominant burst.
 */
`timescale 1ns/1ps
module ccz_bus_node #(
  parameter WAKE_LEN = 8
) (
  input  logic core_clk,
  input  logic resetn,
  input  logic tx_pin,
  input  logic wake_go,
  output logic rx_pin
);
  logic [7:0] cnt_q;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      cnt_q <= 8'h0;
    else if (wake_go)
      cnt_q <= 8'(WAKE_LEN);
    else if (cnt_q != 8'h0)
      cnt_q <= cnt_q - 8'h1;
  end

  // released bus idles recessive, any dominant driver wins
  assign rx_pin = tx_pin & (cnt_q == 8'h0);
endmodule

/* test/ccz_ctl0_tb_top.sv */
/*
 * Self-checking bench for ccz_ctl0 with a bus node on its pins.
 * Assumes the design files, checker and node model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ccz_ctl0_tb_top;
  localparam DIV = 4;
  logic        core_clk = 1'h0, resetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        engine_tx_bit = 1'h1, engine_frame_ok = 1'h0, engine_receiving = 1'h0;
  logic        engine_synced = 1'h1, engine_tx_empty = 1'h1, engine_msg_ack = 1'h0;
  logic        cpu_wait_mode = 1'h0, stamp_take = 1'h0, wake_go = 1'h0, tx_quiet = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [3:0]  engine_msg_buf = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        bus_receive_pin, bus_transmit_pin, engine_abort, init_acknowledge;
  logic        sleep_acknowledge, stamp_ready, stamp_valid;
  logic [19:0] stamp_data;
  int          mismatches = 0, comparisons = 0, cyc = 0, c0, e, cnt, n;

  ccz_ctl0 #(.BIT_DIV(DIV)) dut (.*);
  ccz_bus_node node (.core_clk, .resetn, .tx_pin(bus_transmit_pin), .wake_go,
    .rx_pin(bus_receive_pin));

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    // an idle engine sends recessive, so its own bits cannot wake a sleeping node
    engine_tx_bit <= tx_quiet | 1'($urandom);
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task tick(inout int k);
    k++;
    if (k > 2000) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int  k;
    logic ad, wd;
    k = 0;
    ad = 1'h0;
    wd = 1'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready && !ad) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
      tick(k);
    end while (s_axi_bvalid !== 1'h1);
    `CHK("bresp", er, s_axi_bresp)
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      tick(k);
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] ex);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    `CHK("rdata", ex, v)
    `CHK("rresp", 2'h0, rs)
  endtask

  function logic pick(input int s);
    case (s)
      0: return sleep_acknowledge;
      1: return init_acknowledge;
      default: return stamp_valid;
    endcase
  endfunction

  task automatic waitfor(input int s, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      tick(k);
    end while (pick(s) !== v);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(7));
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    rc(4'h0, 32'h1);
    rc(4'h4, 32'h1);
    `CHK("abort", 1'h1, engine_abort)
    wr(4'h0, 32'hff, 2'h0);
    rc(4'h0, 32'h1);
    wr(4'h0, 32'h0, 2'h0);
    waitfor(1, 1'h0);
    rc(4'h0, 32'h10);
    engine_frame_ok <= 1'h1;
    @(posedge core_clk);
    engine_frame_ok <= 1'h0;
    wr(4'h0, 32'h0, 2'h0);
    rc(4'h0, 32'h90);
    wr(4'h0, 32'h80, 2'h0);
    rc(4'h0, 32'h10);
    // clear written while a new frame arrives: the flag must stay set
    engine_frame_ok <= 1'h1;
    wr(4'h0, 32'h80, 2'h0);
    engine_frame_ok <= 1'h0;
    rc(4'h0, 32'h90);
    wr(4'h0, 32'h80, 2'h0);
    engine_receiving <= 1'h1;
    // status lags the engine by one edge
    @(posedge core_clk);
    rc(4'h0, 32'h50);
    engine_receiving <= 1'h0;
    wr(4'h0, 32'h18, 2'h0);
    c0 = cyc;
    repeat (40) @(posedge core_clk);
    rd(4'h8, d, r);
    e = (cyc - c0) / DIV;
    `CHK("timer", 1'h1, d[15:0] + 2 >= e && d[15:0] <= e + 2)
    engine_msg_buf <= 4'($urandom);
    engine_msg_ack <= 1'h1;
    @(posedge core_clk);
    engine_msg_ack <= 1'h0;
    waitfor(2, 1'h1);
    `CHK("stamp_buf", engine_msg_buf, stamp_data[19:16])
    `CHK("stamp_time", 1'h1, stamp_data[15:0] >= d[15:0] && stamp_data[15:0] <= d[15:0] + 1)
    stamp_take <= 1'h1;
    @(posedge core_clk);
    stamp_take <= 1'h0;
    // overfill: acks beyond the depth must be refused, not overwrite
    engine_msg_ack <= 1'h1;
    repeat (40) @(posedge core_clk);
    engine_msg_ack <= 1'h0;
    `CHK("full", 1'h0, stamp_ready)
    stamp_take <= 1'h1;
    cnt = 0;
    n = 0;
    do begin
      @(posedge core_clk);
      if (stamp_valid)
        cnt++;
      tick(n);
    end while (cnt < 32);
    stamp_take <= 1'h0;
    repeat (2) @(posedge core_clk);
    `CHK("room", 1'h1, stamp_ready)
    wr(4'h0, 32'h10, 2'h0);
    rc(4'h8, 32'h0);
    wr(4'h8, 32'hffff, 2'h0);
    rc(4'h8, 32'h0);
    rd(4'hc, d, r);
    `CHK("bad_resp", 2'h2, r)
    `CHK("bad_data", 32'h0, d)
    wr(4'h0, 32'h20, 2'h0);
    // the engine goes quiet well before sleep is requested
    tx_quiet <= 1'h1;
    cpu_wait_mode <= 1'h1;
    repeat (3) @(posedge core_clk);
    `CHK("stall", 2'h0, {s_axi_awready, s_axi_arready})
    `CHK("tx_wait", 1'h1, bus_transmit_pin)
    cpu_wait_mode <= 1'h0;
    @(posedge core_clk);
    wr(4'h0, 32'h06, 2'h0);
    waitfor(0, 1'h1);
    rc(4'h4, 32'h2);
    `CHK("tx_sleep", 1'h1, bus_transmit_pin)
    wake_go <= 1'h1;
    @(posedge core_clk);
    wake_go <= 1'h0;
    waitfor(0, 1'h0);
    rc(4'h0, 32'h14);
    wr(4'h0, 32'h0d, 2'h0);
    waitfor(1, 1'h1);
    rc(4'h0, 32'h5);
    rc(4'h8, 32'h0);
    close_out();
  end
endmodule
